// *** shared/regbank_pkg.sv ***
// Constants for the regulator command register bank: command codes, field positions, reset values.
// Assumes a serial front end that has already split traffic into command-code reads and byte writes.
// What this block does
// R1: A voltage-monitor warning event sets bit 2 of the alert status byte.
// R2: A voltage-monitor fault event sets bit 1 of the alert status byte.
// R3: Command 0x8B reads back the two-byte output voltage measurement in VID format.
// R4: Command 0x8C reads back the two-byte output current measurement in linear format.
// R5: Command 0xDD reads back the two-byte maximum load current taken from the maximum-current pin.
// R6: Writing one to bit 1 of command 0xD0 returns every register except the lock bit to its power-on value.
// R7: That register reset request is ignored while the lock bit is already set.
// R8: Writing one to bit 0 of command 0xD0 locks the limit settings so that lockable registers reject writes.
// R9: Once set, the lock cannot be cleared by any write and lasts until power is cycled.
// R10: After every startup the slew field, bits 7:5 of command 0xD6, is loaded from the soft-start pin code.
// R11: After startup the host may overwrite the slew field and the new rate is then used.
// R12: Slew code 000 selects 0.125mV/us and each code step doubles the rate up to 16mV/us.
// R13: Reserved bits read as zero and writes to them have no effect.
// R14: Writes to read-only command codes leave their contents unchanged.
package regbank_pkg;

  localparam logic [7:0] CMD_ALERT_STATUS   = 8'h80;
  localparam logic [7:0] CMD_VOUT_READBACK  = 8'h8B;
  localparam logic [7:0] CMD_IOUT_READBACK  = 8'h8C;
  localparam logic [7:0] CMD_MAKER_CODE     = 8'h99;
  localparam logic [7:0] CMD_MODEL_CODE     = 8'h9A;
  localparam logic [7:0] CMD_REVISION_CODE  = 8'h9B;
  localparam logic [7:0] CMD_LOCK_RESET     = 8'hD0;
  localparam logic [7:0] CMD_SLEW_CONTROL   = 8'hD6;
  localparam logic [7:0] CMD_MAX_CURRENT    = 8'hDD;

  localparam int WARN_FLAG_BIT  = 2;
  localparam int FAULT_FLAG_BIT = 1;
  localparam int LOCK_BIT       = 0;
  localparam int SOFT_RESET_BIT = 1;
  localparam int SLEW_MSB       = 7;
  localparam int SLEW_LSB       = 5;
  localparam int SLEW_WIDTH     = SLEW_MSB - SLEW_LSB + 1;

  localparam logic [15:0] READBACK_RESET = 16'h0000;
  localparam logic [15:0] UNMAPPED_READ  = 16'h0000;
  // Rate unit is 0.125mV/us; code 0 gives one unit
  localparam logic [7:0]  SLEW_RATE_BASE = 8'h01;

endpackage

// *** core/regulator_command_register_bank.sv ***
// Register bank for the alert status, readback, identification, lock/reset and slew commands.
// Assumes reads and writes arrive as one-cycle strobes with a command code, synchronous to mclk_i.
`timescale 1ns/1ps
`default_nettype none
module regulator_command_register_bank
  import regbank_pkg::*;
#(
  parameter logic [7:0]  MAKER_CODE    = 8'h5C,    // Value arbitrary
  parameter logic [15:0] MODEL_CODE    = 16'h7E42, // Value arbitrary
  parameter logic [7:0]  REVISION_CODE = 8'h03     // Value arbitrary
) (
  input  wire logic                  mclk_i,
  input  wire logic                  sys_rst_i,
  input  wire logic                  rd_req_i,
  input  wire logic                  wr_req_i,
  input  wire logic [7:0]            cmd_i,
  input  wire logic [7:0]            wr_data_i,
  input  wire logic                  monitor_warning_i,
  input  wire logic                  monitor_fault_i,
  input  wire logic [15:0]           vout_meas_i,
  input  wire logic [15:0]           iout_meas_i,
  input  wire logic [15:0]           max_current_pin_i,
  input  wire logic [SLEW_WIDTH-1:0] soft_start_slew_i,
  output logic                       rd_valid_o,
  output logic [15:0]                rd_data_o,
  output logic                       wr_reject_o,
  output logic                       lock_o,
  output logic [SLEW_WIDTH-1:0]      slew_code_o,
  output logic [7:0]                 slew_rate_o
);

  typedef struct packed {
    logic                  started;
    logic                  warn_flag;
    logic                  fault_flag;
    logic [15:0]           vout;
    logic [15:0]           iout;
    logic [15:0]           max_current;
    logic                  lock;
    logic [SLEW_WIDTH-1:0] slew;
    logic [7:0]            slew_rate;
    logic                  rd_valid;
    logic [15:0]           rd_data;
    logic                  wr_reject;
  } state_type;

  state_type state_reg;
  state_type state_next;

  // Doubling per code step from the 0.125mV/us base
  function automatic logic [7:0] slew_rate_of(input logic [SLEW_WIDTH-1:0] code);
    slew_rate_of = SLEW_RATE_BASE << code; // R12
  endfunction

  function automatic logic [15:0] read_value(input state_type s, input logic [7:0] cmd);
    unique case (cmd)
      CMD_ALERT_STATUS:  read_value = {13'h0000, s.warn_flag, s.fault_flag, 1'b0}; // R1 R2 R13
      CMD_VOUT_READBACK: read_value = s.vout; // R3
      CMD_IOUT_READBACK: read_value = s.iout; // R4
      CMD_MAKER_CODE:    read_value = {8'h00, MAKER_CODE};
      CMD_MODEL_CODE:    read_value = MODEL_CODE;
      CMD_REVISION_CODE: read_value = {8'h00, REVISION_CODE};
      CMD_LOCK_RESET:    read_value = {15'h0000, s.lock}; // R13
      CMD_SLEW_CONTROL:  read_value = {8'h00, s.slew, 5'h00}; // R13
      CMD_MAX_CURRENT:   read_value = s.max_current; // R5
      default:           read_value = UNMAPPED_READ;
    endcase
  endfunction

  always_comb begin
    state_next           = state_reg;
    state_next.rd_valid  = 1'b0;
    state_next.wr_reject = 1'b0;
    // Measurements follow the monitors every cycle except a soft reset cycle, which loads READBACK_RESET
    state_next.vout = vout_meas_i; // R3
    state_next.iout = iout_meas_i; // R4
    // Straps are caught on the first clock after reset release
    if (!state_reg.started) begin
      state_next.started     = 1'b1;
      state_next.slew        = soft_start_slew_i; // R10
      state_next.max_current = max_current_pin_i; // R5
    end
    if (rd_req_i) begin
      state_next.rd_valid = 1'b1;
      state_next.rd_data  = read_value(state_reg, cmd_i);
    end
    if (wr_req_i) begin
      unique case (cmd_i)
        CMD_LOCK_RESET: begin
          if (wr_data_i[SOFT_RESET_BIT] && !state_reg.lock) begin // R7
            state_next.warn_flag   = 1'b0; // R6
            state_next.fault_flag  = 1'b0;
            state_next.slew        = soft_start_slew_i;
            state_next.max_current = max_current_pin_i;
            state_next.vout        = READBACK_RESET;
            state_next.iout        = READBACK_RESET;
          end
          if (wr_data_i[LOCK_BIT]) begin
            state_next.lock = 1'b1; // R9
          end
        end
        CMD_SLEW_CONTROL: begin
          if (state_reg.lock) begin
            state_next.wr_reject = 1'b1; // R8
          end else begin
            state_next.slew = wr_data_i[SLEW_MSB:SLEW_LSB]; // R11 R13
          end
        end
        default: state_next.wr_reject = 1'b1; // R14
      endcase
    end
    // Set wins over a same-cycle soft reset
    if (monitor_warning_i) begin
      state_next.warn_flag = 1'b1; // R1
    end
    if (monitor_fault_i) begin
      state_next.fault_flag = 1'b1; // R2
    end
    state_next.slew_rate = slew_rate_of(state_next.slew); // R12
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rd_valid_o  = state_reg.rd_valid;
  assign rd_data_o   = state_reg.rd_data;
  assign wr_reject_o = state_reg.wr_reject;
  assign lock_o      = state_reg.lock;
  assign slew_code_o = state_reg.slew;
  assign slew_rate_o = state_reg.slew_rate;

endmodule
`default_nettype wire

// *** bench/regbank_checker.sv ***
// Port checker for the regulator command register bank.
// Assumes it is bound into the bank by name and that reset is synchronous.
`timescale 1ns/1ps
`default_nettype none
module regbank_checker
  import regbank_pkg::*;
(
  input wire logic                  mclk_i,
  input wire logic                  sys_rst_i,
  input wire logic                  rd_req_i,
  input wire logic                  wr_req_i,
  input wire logic [7:0]            cmd_i,
  input wire logic [7:0]            wr_data_i,
  input wire logic                  rd_valid_o,
  input wire logic                  wr_reject_o,
  input wire logic                  lock_o,
  input wire logic [SLEW_WIDTH-1:0] slew_code_o,
  input wire logic [7:0]            slew_rate_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  wire logic lw = wr_req_i && cmd_i == CMD_LOCK_RESET;
  wire logic sw = wr_req_i && cmd_i == CMD_SLEW_CONTROL;
  chk_read_answer: assert property (rd_req_i |=> rd_valid_o) else $error("read not answered");
  chk_lone_valid: assert property (!rd_req_i |=> !rd_valid_o) else $error("stray read valid");
  chk_rate_code: assert property (!$past(sys_rst_i) && !$past(sys_rst_i, 2) |->
    slew_rate_o == SLEW_RATE_BASE << slew_code_o) else $error("slew rate wrong");
  chk_lock_hold: assert property (lock_o |=> lock_o) else $error("lock cleared");
  chk_lock_set: assert property (lw && wr_data_i[LOCK_BIT] |=> lock_o) else $error("lock not set");
  chk_ro_reject: assert property (wr_req_i && !lw && !sw |=> wr_reject_o) else $error("no reject");
  chk_slew_locked: assert property (sw && lock_o |=> wr_reject_o && $stable(slew_code_o))
    else $error("locked slew changed");
  chk_slew_write: assert property (sw && !lock_o |=> {slew_code_o, 5'h00} == ($past(wr_data_i) & 8'hE0))
    else $error("slew write lost");
  chk_reset_ignored: assert property (lw && lock_o |=> !wr_reject_o && $stable(slew_code_o))
    else $error("locked reset acted");
endmodule
bind regulator_command_register_bank regbank_checker checker_i (.*);
`default_nettype wire

// *** bench/reg_host.sv ***
// Host model that turns command reads and byte writes into request strobes.
// Assumes the bank answers exactly one cycle after a strobe.
`timescale 1ns/1ps
`default_nettype none
module reg_host (
  input  wire logic        mclk_i,
  input  wire logic        rd_valid_i,
  input  wire logic        wr_reject_i,
  input  wire logic [15:0] rd_data_i,
  output logic             rd_req_o,
  output logic             wr_req_o,
  output logic [7:0]       cmd_o,
  output logic [7:0]       wr_data_o
);
  initial {rd_req_o, wr_req_o, cmd_o, wr_data_o} = '0;
  task automatic xfer(input logic rd, input logic [7:0] c, input logic [7:0] d, output logic [15:0] got);
    @(posedge mclk_i) #1;
    {rd_req_o, wr_req_o, cmd_o, wr_data_o} = {rd, !rd, c, d};
    @(posedge mclk_i) #1;
    {rd_req_o, wr_req_o, cmd_o, wr_data_o} = {2'b00, ~c, ~d};
    got = rd ? (rd_valid_i ? rd_data_i : 'x) : 16'(wr_reject_i);
  endtask
endmodule
`default_nettype wire

// *** bench/testbench.sv ***
// Self-checking bench for the regulator command register bank.
// Assumes the host model drives requests and the checker is bound in.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import regbank_pkg::*;
  logic        mclk_i, sys_rst_i, warn, fault, rdq, wrq, rdv, rej, lock;
  logic [7:0]  cmd, wd, rate;
  logic [2:0]  code, ss = 3'h3;
  logic [15:0] rdat, got, max_current_pin = 16'h0042;
  int          num_errors = 0, check_count = 0;
  regulator_command_register_bank #(.MAKER_CODE(8'h5C), .MODEL_CODE(16'h7E42), .REVISION_CODE(8'h03))
    dut (.mclk_i, .sys_rst_i, .rd_req_i(rdq), .wr_req_i(wrq), .cmd_i(cmd),
    .wr_data_i(wd), .monitor_warning_i(warn), .monitor_fault_i(fault), .vout_meas_i(16'h1234),
    .iout_meas_i(16'h0567), .max_current_pin_i(max_current_pin), .soft_start_slew_i(ss), .rd_valid_o(rdv),
    .rd_data_o(rdat), .wr_reject_o(rej), .lock_o(lock), .slew_code_o(code), .slew_rate_o(rate));
  reg_host host (.mclk_i, .rd_valid_i(rdv), .wr_reject_i(rej), .rd_data_i(rdat), .rd_req_o(rdq),
    .wr_req_o(wrq), .cmd_o(cmd), .wr_data_o(wd));
  initial begin
    mclk_i = 0;
    forever #2 mclk_i = ~mclk_i;
  end
  task automatic results;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      $display("wrong value at %0t: got %h want %h", $time, g, e);
      num_errors++;
    end
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    host.xfer(1'b1, c, 8'h00, got);
    chk(got, e);
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] d, input logic [15:0] e);
    host.xfer(1'b0, c, d, got);
    chk(got, e);
  endtask
  task automatic t_read;
    rd(CMD_VOUT_READBACK, 16'h1234);
    rd(CMD_IOUT_READBACK, 16'h0567);
    rd(CMD_MAX_CURRENT, max_current_pin);
    rd(CMD_SLEW_CONTROL, {13'h0000, ss} << 5);
    wr(CMD_VOUT_READBACK, 8'hFF, 16'h0001);
    rd(CMD_VOUT_READBACK, 16'h1234);
    rd(CMD_MAKER_CODE, 16'h005C);
    rd(CMD_REVISION_CODE, 16'h0003);
    wr(CMD_MODEL_CODE, 8'h00, 16'h0001);
    rd(CMD_MODEL_CODE, 16'h7E42);
    rd(8'h42, 16'h0000);
    $display("test read done");
  endtask
  task automatic t_slew;
    for (int i = 0; i < 8; i++) begin
      wr(CMD_SLEW_CONTROL, 8'(i << 5) | 8'h1F, 16'h0000);
      chk({8'h00, rate}, 16'h0001 << i);
      rd(CMD_SLEW_CONTROL, 16'(i << 5));
    end
    $display("test slew done");
  endtask
  task automatic t_flags;
    warn = 1;
    @(posedge mclk_i) #1 warn = 0;
    rd(CMD_ALERT_STATUS, 16'h0004);
    fault = 1;
    @(posedge mclk_i) #1 fault = 0;
    rd(CMD_ALERT_STATUS, 16'h0006);
    wr(CMD_LOCK_RESET, 8'h02, 16'h0000);
    rd(CMD_ALERT_STATUS, 16'h0000);
    rd(CMD_SLEW_CONTROL, {13'h0000, ss} << 5);
    $display("test flags done");
  endtask
  task automatic t_lock;
    warn = 1;
    @(posedge mclk_i) #1 warn = 0;
    wr(CMD_LOCK_RESET, 8'h01, 16'h0000);
    wr(CMD_SLEW_CONTROL, 8'hE0, 16'h0001);
    wr(CMD_LOCK_RESET, 8'h02, 16'h0000);
    rd(CMD_ALERT_STATUS, 16'h0004);
    wr(CMD_LOCK_RESET, 8'h00, 16'h0000);
    chk({15'h0000, lock}, 16'h0001);
    $display("test lock done");
  endtask
  initial begin
    warn = 0;
    fault = 0;
    sys_rst_i = 1;
    repeat (8) @(posedge mclk_i);
    #1 sys_rst_i = 0;
    t_read;
    t_slew;
    t_flags;
    t_lock;
    results;
  end
  initial begin
    #20000;
    num_errors++;
    results;
  end
endmodule
`default_nettype wire
